// [rtl/flash_seq_pkg.sv]
package flash_seq_pkg;
  // program word layout
  localparam int INSTR_W    = 24;
  localparam int DATA_W     = 16;
  localparam int HIGH_W     = 8;
  localparam int ADDR_W     = 24;
  localparam int WADDR_W    = 23;
  localparam int ROW_WORDS  = 64;
  localparam int ROW_IDX_W  = 6;
  localparam int PAGE_ROWS  = 8;
  localparam int PAGE_WORDS = 512;
  localparam int PAGE_IDX_W = 9;

  // register index on the plain register port
  localparam int REG_AW = 3;
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_KEY    = 3'h1;
  localparam logic [2:0] REG_PTR_LO = 3'h2;
  localparam logic [2:0] REG_PTR_HI = 3'h3;
  localparam logic [2:0] REG_TBL_LO = 3'h4;
  localparam logic [2:0] REG_TBL_HI = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // control register fields
  localparam int CTRL_START_BIT  = 15;
  localparam int CTRL_ERR_BIT    = 13;
  localparam int CTRL_TARGET_BIT = 6;
  localparam int CTRL_OP_LSB     = 0;
  localparam int OP_W            = 4;
  localparam logic [3:0] OP_ROW  = 4'h1;
  localparam logic [3:0] OP_PAGE = 4'h2;
  localparam logic [3:0] OP_WORD = 4'h3;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;

  // unlock key values
  localparam logic [15:0] KEY_FIRST  = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;

  // durations in fast_rc_oscillator cycles
  localparam int CYC_W        = 18;
  localparam int ROW_CYC_DEF  = 11064;
  localparam int WORD_CYC_DEF = 400;
  localparam int PAGE_CYC_DEF = 12000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } seq_state_type;

  typedef enum logic [1:0] {
    KEY_NONE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_ARMED = 2'b11
  } key_state_type;

  typedef enum logic [1:0] {
    FCMD_NONE = 2'b00,
    FCMD_WORD = 2'b01,
    FCMD_ROW  = 2'b10,
    FCMD_PAGE = 2'b11
  } fcmd_type;
endpackage

// [rtl/flash_seq_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface flash_seq_if;
  logic                                wrEn;
  logic                                wrHigh;
  logic [flash_seq_pkg::ROW_IDX_W-1:0] wrIdx;
  logic [flash_seq_pkg::DATA_W-1:0]    wrData;
  logic [flash_seq_pkg::ROW_IDX_W-1:0] rdIdx;
  logic [flash_seq_pkg::INSTR_W-1:0]   rdData;
  logic                                frcTick;
  logic                                tmrStart;
  logic [flash_seq_pkg::CYC_W-1:0]     tmrLoad;
  logic                                tmrDone;

  modport ctl (output wrEn, wrHigh, wrIdx, wrData, rdIdx, frcTick, tmrStart,
               tmrLoad, input rdData, tmrDone);
  modport mem (input wrEn, wrHigh, wrIdx, wrData, rdIdx, output rdData);
  modport tmr (input frcTick, tmrStart, tmrLoad, output tmrDone);
endinterface
`default_nettype wire

// [rtl/row_latch_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module row_latch_mem #(
  parameter int DEPTH = flash_seq_pkg::ROW_WORDS
) (
  input wire logic  sys_clk,
  flash_seq_if.mem  bus
);
  logic [flash_seq_pkg::DATA_W-1:0] lowWord [DEPTH];
  logic [flash_seq_pkg::HIGH_W-1:0] highByte [DEPTH];

  generate
    if (DEPTH != (1 << flash_seq_pkg::ROW_IDX_W)) begin : g_chk
      $error("latch depth must match the row index width");
    end
  endgenerate

  // latch writes never touch the array
  always_ff @(posedge sys_clk) begin
    if (bus.wrEn && !bus.wrHigh) begin
      lowWord[bus.wrIdx] <= bus.wrData;
    end
    if (bus.wrEn && bus.wrHigh) begin
      highByte[bus.wrIdx] <= bus.wrData[flash_seq_pkg::HIGH_W-1:0];
    end
  end

  // registered read, upper byte of upper word unimplemented
  always_ff @(posedge sys_clk) begin
    bus.rdData <= {highByte[bus.rdIdx], lowWord[bus.rdIdx]};
  end
endmodule
`default_nettype wire

// [rtl/flash_op_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_op_timer (
  input wire logic  sys_clk,
  input wire logic  arst_n,
  flash_seq_if.tmr  bus
);
  logic [flash_seq_pkg::CYC_W-1:0] cnt_r;
  logic                            running_r;

  // counts oscillator ticks, not system clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      running_r <= 1'b0;
    end else if (bus.tmrStart) begin
      cnt_r <= bus.tmrLoad;
      running_r <= 1'b1;
    end else if (running_r && bus.frcTick) begin
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == 1) begin
        running_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.tmrDone <= 1'b0;
    end else begin
      bus.tmrDone <= running_r && bus.frcTick && (cnt_r == 1);
    end
  end
endmodule
`default_nettype wire

// [rtl/flash_self_program_sequencer.sv]
// What this block does
// - program words are 24 bits: low word plus low byte of high word.
// - a programming row holds 64 instruction words, 192 bytes.
// - erase clears one page of eight rows, 512 words, in one go.
// - programming writes one whole row or one single word.
// - page and row addresses are aligned; low bits inside them ignored.
// - 64 holding latches, filled in order from a 64-word boundary.
// - table writes touch only the latches and take two cycles.
// - each row needs its own operation; never more than one row.
// - core is stalled while erase or program runs.
// - durations count oscillator cycles; row write lasts 11064 cycles.
// - start bit 15 launches operation and clears itself when finished.
// - control register selects operation, target memory and start.
// - key register is write-only and reads back as zero.
// - start accepted only after 0x55 then 0xAA written consecutively.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer #(
  parameter int ROW_CYC  = flash_seq_pkg::ROW_CYC_DEF,
  parameter int WORD_CYC = flash_seq_pkg::WORD_CYC_DEF,
  parameter int PAGE_CYC = flash_seq_pkg::PAGE_CYC_DEF
) (
  input  wire logic                                sys_clk,
  input  wire logic                                arst_n,
  input  wire logic [flash_seq_pkg::REG_AW-1:0]    regAddr,
  input  wire logic [flash_seq_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                                regWr,
  input  wire logic                                regRd,
  output logic      [flash_seq_pkg::DATA_W-1:0]    regRdData_r,
  input  wire logic                                frcTick,
  output logic                                     cpuStall_r,
  output logic      [flash_seq_pkg::WADDR_W-1:0]   flashAddr_r,
  output logic      [flash_seq_pkg::INSTR_W-1:0]   flashData_r,
  output logic                                     flashLoad_r,
  output logic      [1:0]                          flashCmd_r,
  output logic                                     flashGo_r,
  output logic                                     flashBusy_r
);
  localparam int MAXC = (1 << flash_seq_pkg::CYC_W) - 1;

  generate
    if (ROW_CYC < 1 || WORD_CYC < 1 || PAGE_CYC < 1 || ROW_CYC > MAXC ||
        WORD_CYC > MAXC || PAGE_CYC > MAXC) begin : g_chk
      $error("operation cycle counts out of range");
    end
  endgenerate

  flash_seq_if sif ();

  row_latch_mem #(
    .DEPTH (flash_seq_pkg::ROW_WORDS)
  ) u_mem (
    .sys_clk (sys_clk),
    .bus     (sif.mem)
  );

  flash_op_timer u_tmr (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .bus     (sif.tmr)
  );

  flash_seq_pkg::seq_state_type        state_r;
  flash_seq_pkg::key_state_type        key_r;
  flash_seq_pkg::fcmd_type             cmd_r;
  logic [flash_seq_pkg::OP_W-1:0]      opSel_r;
  logic                                target_r;
  logic                                start_r;
  logic                                err_r;
  logic [flash_seq_pkg::ADDR_W-1:0]    ptr_r;
  logic [flash_seq_pkg::ROW_IDX_W:0]   ldLeft_r;
  logic [flash_seq_pkg::ROW_IDX_W-1:0] ldIdx_r;
  logic [flash_seq_pkg::ROW_IDX_W-1:0] pendIdx_r;
  logic                                pend_r;
  logic                                tmrStart_r;
  logic [flash_seq_pkg::CYC_W-1:0]     tmrLoad_r;

  logic                                wrCtrl;
  logic                                wrTbl;
  logic                                startReq;
  logic                                opValid;
  logic                                launch;
  logic                                refused;
  logic [flash_seq_pkg::WADDR_W-1:0]   wordAddr;
  flash_seq_pkg::fcmd_type             reqCmd;

  function automatic flash_seq_pkg::fcmd_type opToCmd(
    input logic [flash_seq_pkg::OP_W-1:0] op);
    case (op)
      flash_seq_pkg::OP_ROW:  opToCmd = flash_seq_pkg::FCMD_ROW;
      flash_seq_pkg::OP_PAGE: opToCmd = flash_seq_pkg::FCMD_PAGE;
      flash_seq_pkg::OP_WORD: opToCmd = flash_seq_pkg::FCMD_WORD;
      default:                opToCmd = flash_seq_pkg::FCMD_NONE;
    endcase
  endfunction

  assign wrCtrl = regWr && (regAddr == flash_seq_pkg::REG_CTRL);
  assign wrTbl  = regWr && ((regAddr == flash_seq_pkg::REG_TBL_LO) ||
                            (regAddr == flash_seq_pkg::REG_TBL_HI));
  assign reqCmd   = opToCmd(regWrData[flash_seq_pkg::CTRL_OP_LSB +:
                                      flash_seq_pkg::OP_W]);
  assign opValid  = (reqCmd != flash_seq_pkg::FCMD_NONE) &&
                    regWrData[flash_seq_pkg::CTRL_TARGET_BIT];
  assign startReq = wrCtrl && regWrData[flash_seq_pkg::CTRL_START_BIT];
  assign launch   = startReq && opValid &&
                    (key_r == flash_seq_pkg::KEY_ARMED) &&
                    (state_r == flash_seq_pkg::ST_IDLE);
  assign refused  = startReq && !launch;
  assign wordAddr = ptr_r[flash_seq_pkg::ADDR_W-1:1];

  assign sif.wrEn    = wrTbl;
  assign sif.wrHigh  = (regAddr == flash_seq_pkg::REG_TBL_HI);
  assign sif.wrIdx   = wordAddr[flash_seq_pkg::ROW_IDX_W-1:0];
  assign sif.wrData  = regWrData;
  assign sif.rdIdx   = ldIdx_r;
  assign sif.frcTick = frcTick;
  assign sif.tmrStart = tmrStart_r;
  assign sif.tmrLoad  = tmrLoad_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_r <= flash_seq_pkg::KEY_NONE;
    end else if (regWr) begin
      if (regAddr == flash_seq_pkg::REG_KEY &&
          regWrData == flash_seq_pkg::KEY_FIRST) begin
        key_r <= flash_seq_pkg::KEY_HALF;
      end else if (regAddr == flash_seq_pkg::REG_KEY &&
                   regWrData == flash_seq_pkg::KEY_SECOND &&
                   key_r == flash_seq_pkg::KEY_HALF) begin
        key_r <= flash_seq_pkg::KEY_ARMED;
      end else begin
        key_r <= flash_seq_pkg::KEY_NONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opSel_r  <= flash_seq_pkg::CTRL_RST[flash_seq_pkg::CTRL_OP_LSB +:
                                          flash_seq_pkg::OP_W];
      target_r <= flash_seq_pkg::CTRL_RST[flash_seq_pkg::CTRL_TARGET_BIT];
    end else if (wrCtrl && state_r == flash_seq_pkg::ST_IDLE) begin
      opSel_r  <= regWrData[flash_seq_pkg::CTRL_OP_LSB +:
                            flash_seq_pkg::OP_W];
      target_r <= regWrData[flash_seq_pkg::CTRL_TARGET_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_r <= flash_seq_pkg::CTRL_RST[flash_seq_pkg::CTRL_START_BIT];
    end else if (launch) begin
      start_r <= 1'b1;
    end else if (state_r == flash_seq_pkg::ST_DONE) begin
      start_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_r <= flash_seq_pkg::CTRL_RST[flash_seq_pkg::CTRL_ERR_BIT];
    end else if (refused) begin
      err_r <= 1'b1;
    end else if (wrCtrl && !regWrData[flash_seq_pkg::CTRL_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= '0;
    end else if (regWr && regAddr == flash_seq_pkg::REG_PTR_LO) begin
      ptr_r[flash_seq_pkg::DATA_W-1:0] <= regWrData;
    end else if (regWr && regAddr == flash_seq_pkg::REG_PTR_HI) begin
      ptr_r[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::DATA_W] <=
        regWrData[flash_seq_pkg::HIGH_W-1:0];
    end
  end

  // sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= flash_seq_pkg::ST_IDLE;
      cmd_r      <= flash_seq_pkg::FCMD_NONE;
      ldLeft_r   <= '0;
      ldIdx_r    <= '0;
      tmrStart_r <= 1'b0;
      tmrLoad_r  <= '0;
    end else begin
      tmrStart_r <= 1'b0;
      case (state_r)
        flash_seq_pkg::ST_IDLE: begin
          if (launch) begin
            cmd_r <= reqCmd;
            if (reqCmd == flash_seq_pkg::FCMD_PAGE) begin
              state_r    <= flash_seq_pkg::ST_WAIT;
              tmrStart_r <= 1'b1;
              tmrLoad_r  <= flash_seq_pkg::CYC_W'(PAGE_CYC);
            end else if (reqCmd == flash_seq_pkg::FCMD_ROW) begin
              state_r  <= flash_seq_pkg::ST_LOAD;
              ldIdx_r  <= '0;
              ldLeft_r <= (flash_seq_pkg::ROW_IDX_W + 1)'
                          (flash_seq_pkg::ROW_WORDS);
            end else begin
              state_r  <= flash_seq_pkg::ST_LOAD;
              ldIdx_r  <= wordAddr[flash_seq_pkg::ROW_IDX_W-1:0];
              ldLeft_r <= (flash_seq_pkg::ROW_IDX_W + 1)'(1);
            end
          end
        end
        flash_seq_pkg::ST_LOAD: begin
          if (ldLeft_r != 0) begin
            ldLeft_r <= ldLeft_r - 1'b1;
            ldIdx_r  <= ldIdx_r + 1'b1;
          end else if (!pend_r) begin
            state_r    <= flash_seq_pkg::ST_WAIT;
            tmrStart_r <= 1'b1;
            tmrLoad_r  <= (cmd_r == flash_seq_pkg::FCMD_ROW) ?
                          flash_seq_pkg::CYC_W'(ROW_CYC) :
                          flash_seq_pkg::CYC_W'(WORD_CYC);
          end
        end
        flash_seq_pkg::ST_WAIT: begin
          if (sif.tmrDone) begin
            state_r <= flash_seq_pkg::ST_DONE;
          end
        end
        flash_seq_pkg::ST_DONE: begin
          state_r <= flash_seq_pkg::ST_IDLE;
        end
        default: begin
          state_r <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // latch read pipeline towards the array
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r    <= 1'b0;
      pendIdx_r <= '0;
    end else begin
      pend_r    <= (state_r == flash_seq_pkg::ST_LOAD) && (ldLeft_r != 0);
      pendIdx_r <= ldIdx_r;
    end
  end

  // array port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flashAddr_r <= '0;
      flashData_r <= '0;
      flashLoad_r <= 1'b0;
      flashCmd_r  <= flash_seq_pkg::FCMD_NONE;
      flashGo_r   <= 1'b0;
      flashBusy_r <= 1'b0;
    end else begin
      flashLoad_r <= pend_r;
      flashGo_r   <= tmrStart_r;
      flashBusy_r <= (state_r == flash_seq_pkg::ST_WAIT) ||
                     tmrStart_r;
      if (launch) begin
        flashCmd_r <= reqCmd;
      end
      if (pend_r) begin
        flashAddr_r <= {wordAddr[flash_seq_pkg::WADDR_W-1:
                                 flash_seq_pkg::ROW_IDX_W], pendIdx_r};
        flashData_r <= sif.rdData;
      end else if (tmrStart_r && cmd_r == flash_seq_pkg::FCMD_PAGE) begin
        flashAddr_r <= {wordAddr[flash_seq_pkg::WADDR_W-1:
                                 flash_seq_pkg::PAGE_IDX_W],
                        {flash_seq_pkg::PAGE_IDX_W{1'b0}}};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuStall_r <= 1'b0;
    end else begin
      cpuStall_r <= launch || wrTbl ||
                    (state_r == flash_seq_pkg::ST_LOAD) ||
                    (state_r == flash_seq_pkg::ST_WAIT);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_r <= '0;
    end else begin
      regRdData_r <= '0;
      if (regRd) begin
        case (regAddr)
          flash_seq_pkg::REG_CTRL: begin
            regRdData_r[flash_seq_pkg::CTRL_START_BIT]  <= start_r;
            regRdData_r[flash_seq_pkg::CTRL_ERR_BIT]    <= err_r;
            regRdData_r[flash_seq_pkg::CTRL_TARGET_BIT] <= target_r;
            regRdData_r[flash_seq_pkg::CTRL_OP_LSB +:
                        flash_seq_pkg::OP_W]            <= opSel_r;
          end
          flash_seq_pkg::REG_PTR_LO: begin
            regRdData_r <= ptr_r[flash_seq_pkg::DATA_W-1:0];
          end
          flash_seq_pkg::REG_PTR_HI: begin
            regRdData_r[flash_seq_pkg::HIGH_W-1:0] <=
              ptr_r[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::DATA_W];
          end
          flash_seq_pkg::REG_STATUS: begin
            regRdData_r[flash_seq_pkg::STAT_BUSY_BIT] <=
              (state_r != flash_seq_pkg::ST_IDLE);
            regRdData_r[flash_seq_pkg::STAT_ERR_BIT] <= err_r;
          end
          default: begin
            regRdData_r <= '0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [dv/flash_self_program_sequencer_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_asserts #(
  parameter int ROW_CYC  = 20,
  parameter int WORD_CYC = 5,
  parameter int PAGE_CYC = 10
) (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [2:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData_r,
  input wire logic        frcTick,
  input wire logic        cpuStall_r,
  input wire logic [22:0] flashAddr_r,
  input wire logic [23:0] flashData_r,
  input wire logic        flashLoad_r,
  input wire logic [1:0]  flashCmd_r,
  input wire logic        flashGo_r,
  input wire logic        flashBusy_r
);
  logic [1:0] keySt;
  logic [6:0] loadCnt;
  logic [1:0] opCmd;
  logic       startOk;
  logic       ctrlStart;
  int         tickCnt;
  int         opCyc;

  assign ctrlStart = regWr && regAddr == flash_seq_pkg::REG_CTRL
                     && regWrData[15];
  assign startOk = keySt == 2'h2 && regWrData[6]
                   && regWrData[3:0] inside {4'h1, 4'h2, 4'h3};
  assign opCyc = opCmd == 2'h2 ? ROW_CYC
               : opCmd == 2'h1 ? WORD_CYC : PAGE_CYC;

  // key progress seen on the bus
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) keySt <= 2'h0;
    else if (regWr) begin
      if (regAddr == flash_seq_pkg::REG_KEY
          && regWrData == flash_seq_pkg::KEY_FIRST) keySt <= 2'h1;
      else if (regAddr == flash_seq_pkg::REG_KEY && keySt == 2'h1
               && regWrData == flash_seq_pkg::KEY_SECOND) keySt <= 2'h2;
      else keySt <= 2'h0;
    end
  end

  // words loaded during one stall
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) loadCnt <= 7'h00;
    else if (!cpuStall_r) loadCnt <= 7'h00;
    else if (flashLoad_r) loadCnt <= loadCnt + 7'h01;
  end

  // oscillator ticks while busy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 0;
      opCmd <= 2'h0;
    end else if (flashGo_r) begin
      tickCnt <= int'(frcTick);
      opCmd <= flashCmd_r;
    end else if (flashBusy_r && frcTick) tickCnt <= tickCnt + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_rd_idle;
    !$past(regRd) |-> regRdData_r == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  property p_key_rd;
    regRd && regAddr == flash_seq_pkg::REG_KEY |=> regRdData_r == 16'h0000;
  endproperty
  a_key_rd: assert property (p_key_rd)
    else $error("key readable");
  property p_launch;
    ctrlStart && startOk && !cpuStall_r
      |=> cpuStall_r ##[1:2] (flashGo_r || flashLoad_r);
  endproperty
  a_launch: assert property (p_launch)
    else $error("no launch");
  property p_refuse;
    ctrlStart && !startOk |=> (!flashLoad_r && !flashGo_r) [*8];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused start ran");
  property p_busy_stall;
    flashBusy_r |-> cpuStall_r;
  endproperty
  a_busy_stall: assert property (p_busy_stall)
    else $error("busy unstalled");
  property p_load_cnt;
    flashGo_r |-> loadCnt == (flashCmd_r == 2'h2 ? 7'h40
                            : flashCmd_r == 2'h1 ? 7'h01 : 7'h00);
  endproperty
  a_load_cnt: assert property (p_load_cnt)
    else $error("load count");
  property p_load_seq;
    flashLoad_r && $past(flashLoad_r) |-> flashCmd_r == 2'h2
      && flashAddr_r == $past(flashAddr_r) + 23'h000001;
  endproperty
  a_load_seq: assert property (p_load_seq)
    else $error("load order");
  property p_row_base;
    $rose(flashLoad_r) && flashCmd_r == 2'h2 |-> flashAddr_r[5:0] == 6'h00;
  endproperty
  a_row_base: assert property (p_row_base)
    else $error("row base");
  property p_page_base;
    flashGo_r && flashCmd_r == 2'h3 |-> flashAddr_r[8:0] == 9'h000;
  endproperty
  a_page_base: assert property (p_page_base)
    else $error("page base");
  property p_dur;
    $fell(flashBusy_r) |-> !cpuStall_r && tickCnt >= opCyc - 2
                           && tickCnt <= opCyc + 2;
  endproperty
  a_dur: assert property (p_dur)
    else $error("op length");

  c_row: cover property (flashGo_r && flashCmd_r == 2'h2);
  c_word: cover property (flashGo_r && flashCmd_r == 2'h1);
  c_page: cover property (flashGo_r && flashCmd_r == 2'h3);
  c_refuse: cover property (ctrlStart && !startOk);
endmodule
`default_nettype wire

// [dv/flash_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [22:0] flashAddr_r,
  input wire logic [23:0] flashData_r,
  input wire logic        flashLoad_r,
  input wire logic [1:0]  flashCmd_r,
  input wire logic        flashGo_r,
  output logic            frcTick,
  input wire logic [9:0]  probeAddr,
  output logic [23:0]     probeData
);
  logic [23:0] mem [0:1023];
  logic [1:0]  gap;

  initial for (int i = 0; i < 1024; i++) mem[i] = 24'hFFFFFF;
  assign probeData = mem[probeAddr];

  // free running oscillator, uneven spacing
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frcTick <= 1'b0;
      gap <= 2'h0;
    end else if (gap == 2'h0) begin
      frcTick <= 1'b1;
      gap <= 2'($urandom_range(0, 2));
    end else begin
      frcTick <= 1'b0;
      gap <= gap - 2'h1;
    end
  end

  always @(posedge sys_clk) begin
    if (flashLoad_r) mem[flashAddr_r[9:0]] <= flashData_r;
    else if (flashGo_r && flashCmd_r == 2'h3)
      for (int i = 0; i < 512; i++) mem[{flashAddr_r[9], 9'(i)}] <= 24'hFFFFFF;
  end
endmodule
`default_nettype wire

// [dv/flash_self_program_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_test;
  localparam int ROW_CYC = 20;
  localparam int WORD_CYC = 5;
  localparam int PAGE_CYC = 10;
  localparam logic [22:0] ROW_BASE = 23'h000140;
  localparam logic [2:0] CTRL = flash_seq_pkg::REG_CTRL;
  localparam logic [2:0] STAT = flash_seq_pkg::REG_STATUS;
  localparam logic [2:0] KEY = flash_seq_pkg::REG_KEY;
  logic        sys_clk, arst_n, regWr, regRd, frcTick, cpuStall_r;
  logic        flashLoad_r, flashGo_r, flashBusy_r;
  logic [2:0]  regAddr;
  logic [15:0] regWrData, regRdData_r;
  logic [22:0] flashAddr_r;
  logic [23:0] flashData_r, probeData;
  logic [1:0]  flashCmd_r;
  logic [9:0]  probeAddr;
  logic [31:0] w;
  logic [23:0] rowData [64];
  logic [48:0] loadQ [$];
  logic [15:0] rdQ [$];
  logic        rdSeen = 1'b0;
  int          numErrors = 0, checkCount = 0, cycles = 0;

  flash_self_program_sequencer #(.ROW_CYC(ROW_CYC), .WORD_CYC(WORD_CYC),
    .PAGE_CYC(PAGE_CYC)) dut_u (.*);
  flash_array_model flash_u (.*);

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [48:0] expV, gotV);
    checkCount++;
    if (gotV !== expV) begin
      numErrors++;
      $display("MISMATCH at %0t: expected %h got %h", $time, expV, gotV);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regWr <= 1'b1;
    regRd <= 1'b0;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    regRd <= 1'b1;
    regWr <= 1'b0;
    regAddr <= a;
    rdQ.push_back(e);
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic unlock();
    wr(KEY, flash_seq_pkg::KEY_FIRST);
    wr(KEY, flash_seq_pkg::KEY_SECOND);
  endtask
  task automatic tbl(input logic [15:0] p);
    w = $urandom;
    wr(flash_seq_pkg::REG_PTR_LO, p);
    wr(flash_seq_pkg::REG_TBL_LO, w[15:0]);
    idle(1);
    wr(flash_seq_pkg::REG_TBL_HI, w[31:16]);
    idle(1);
  endtask
  task automatic wait_done();
    int n;
    idle(1);
    for (n = 0; n < 500; n++) begin
      @(negedge sys_clk);
      if (cpuStall_r === 1'b0) break;
    end
    check(49'h0, 49'(cpuStall_r));
    @(posedge sys_clk);
  endtask
  task automatic probe(input logic [9:0] a, input logic [23:0] e);
    probeAddr <= a;
    idle(2);
    check(49'(e), 49'(probeData));
  endtask

  // read answers and array loads against the oldest note
  always @(posedge sys_clk) begin
    if (rdSeen) check(49'(rdQ.pop_front()), 49'(regRdData_r));
    if (flashLoad_r === 1'b1)
      check(loadQ.size() ? loadQ.pop_front() : '1,
            {flashAddr_r, flashData_r, flashCmd_r});
    rdSeen <= regRd;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      test_done();
    end
  end

  initial begin
    arst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    probeAddr = 10'h000;
    void'($urandom(32'h6EFF));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(CTRL, flash_seq_pkg::CTRL_RST);
    rd(STAT, 16'h0000);
    wr(KEY, flash_seq_pkg::KEY_FIRST);
    rd(KEY, 16'h0000);
    rd(3'h7, 16'h0000);
    for (int c = 0; c < 6; c++) begin
      case (c)
        1: begin
          wr(KEY, flash_seq_pkg::KEY_FIRST);
          wr(flash_seq_pkg::REG_PTR_HI, 16'h0000);
          wr(KEY, flash_seq_pkg::KEY_SECOND);
        end
        2: begin
          unlock();
          wr(flash_seq_pkg::REG_PTR_HI, 16'h0000);
        end
        3, 4: unlock();
        5: begin
          wr(KEY, flash_seq_pkg::KEY_SECOND);
          wr(KEY, flash_seq_pkg::KEY_FIRST);
        end
        default: ;
      endcase
      wr(CTRL, c == 3 ? 16'h8040 : c == 4 ? 16'h8001 : 16'h8041);
      idle(9);
      rd(STAT, 16'h0002);
      wr(CTRL, 16'h0041);
      rd(STAT, 16'h0000);
    end
    wr(flash_seq_pkg::REG_PTR_HI, 16'h0000);
    for (int i = 0; i < 64; i++) begin
      tbl(16'h0280 + 16'(2 * i + i % 2));
      rowData[i] = w[23:0];
      loadQ.push_back({ROW_BASE + 23'(i), w[23:0], 2'h2});
    end
    probe(10'h145, 24'hFFFFFF);
    unlock();
    wr(CTRL, 16'h8041);
    wait_done();
    rd(CTRL, 16'h0041);
    rd(STAT, 16'h0000);
    probe(10'h145, rowData[5]);
    tbl(16'h034E);
    loadQ.push_back({23'h0001A7, w[23:0], 2'h1});
    unlock();
    wr(CTRL, 16'h8043);
    wait_done();
    probe(10'h1A7, w[23:0]);
    wr(flash_seq_pkg::REG_PTR_LO, 16'h01E6);
    unlock();
    wr(CTRL, 16'h8042);
    wait_done();
    rd(CTRL, 16'h0042);
    probe(10'h145, 24'hFFFFFF);
    probe(10'h1A7, 24'hFFFFFF);
    idle(4);
    check(49'h0, 49'(loadQ.size()));
    test_done();
  end
endmodule

bind flash_self_program_sequencer flash_self_program_sequencer_asserts #(
  .ROW_CYC(ROW_CYC), .WORD_CYC(WORD_CYC), .PAGE_CYC(PAGE_CYC)) chk_u (.*);
`default_nettype wire
